//--- mat_pkg.sv
// constants and types for the microstep angle translator
package mat_pkg;

	// ****************************************
	// widths and table geometry
	// ****************************************
	localparam int ANGLE_W = 6;
	localparam int MAG_W = 6;
	localparam int RES_W = 3;
	localparam logic [5:0] ANGLE_MAX = 6'h3f;
	localparam logic [5:0] HOME_ANGLE = 6'h08;
	localparam logic [5:0] HOME_ANGLE_FULL1 = 6'h00;
	localparam logic [5:0] FULL2_OFFSET = 6'h08;
	localparam logic [5:0] ZERO_OFFSET = 6'h00;
	// electrical advance per increment, in thousandths of a degree
	localparam int DEG_PER_STEP_MILLI = 5625;

	// ****************************************
	// grid spacing per resolution
	// ****************************************
	localparam logic [5:0] GRID_FULL = 6'h10;
	localparam logic [5:0] GRID_HALF = 6'h08;
	localparam logic [5:0] GRID_QUARTER = 6'h04;
	localparam logic [5:0] GRID_EIGHTH = 6'h02;
	localparam logic [5:0] GRID_SIXTEENTH = 6'h01;

	// ****************************************
	// resolution select encodings
	// ****************************************
	localparam logic [2:0] RES_FULL1 = 3'h0;
	localparam logic [2:0] RES_HALF_COMP = 3'h1;
	localparam logic [2:0] RES_QUARTER = 3'h2;
	localparam logic [2:0] RES_EIGHTH = 3'h3;
	localparam logic [2:0] RES_SIXTEENTH = 3'h4;
	localparam logic [2:0] RES_FULL2 = 3'h5;
	localparam logic [2:0] RES_HALF_UNCOMP = 3'h6;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0] MAG_RESET = 6'h00;

	// one-hot control state
	typedef enum logic [1:0] {
		ST_HOME = 2'b01,
		ST_RUN = 2'b10
	} mat_state_type;

	// per-edge step request taken straight from the direction and resolution pins, without synchronisation
	typedef struct packed {
		logic dir_fwd;
		logic [2:0] res;
	} mat_req_type;

	// drive word handed to the current regulator
	typedef struct packed {
		logic [5:0] angle;
		logic [5:0] mag_a;
		logic [5:0] mag_b;
		logic compensated;
	} mat_drive_type;

endpackage : mat_pkg

//--- mat_step_sync.sv
// step input synchroniser with rising edge detector
`timescale 1ns/1ns
module mat_step_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// raw step pin
	input wire logic step_in,
	// one-cycle pulse per rising edge
	output logic step_rise
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// two-flop synchroniser; the first stage feeds only the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= step_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edge taken from the settled stage only
	assign step_rise = sync_reg & ~prev_reg;

endmodule : mat_step_sync

//--- mat_translator.sv
// step and direction translator producing the phase table angle
`timescale 1ns/1ns
module mat_translator (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// controller pins
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic [2:0] resolution_select,
	input wire logic sleep_in,
	// phase current table entry at angle_out
	input wire logic [5:0] table_mag_a,
	input wire logic [5:0] table_mag_b,
	input wire logic [5:0] full_scale_phase_entry,
	// results
	output logic [5:0] angle_out,
	output mat_pkg::mat_drive_type drive_out,
	output logic step_done
);

	// ****************************************
	// declarations
	// ****************************************
	logic step_rise;
	mat_pkg::mat_req_type req;
	mat_pkg::mat_state_type state_reg;
	mat_pkg::mat_state_type state_next;
	logic [5:0] angle_reg;
	logic [5:0] angle_next;
	logic [5:0] home_sel;
	logic [5:0] grid;
	logic [5:0] offset;
	logic [5:0] rel;
	logic [5:0] rel_floor;
	logic [5:0] rel_new;
	logic uncomp;
	mat_pkg::mat_drive_type drive_reg;
	logic done_reg;

	// ****************************************
	// step edge detection
	// ****************************************
	mat_step_sync u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.step_in(step_in),
		.step_rise(step_rise)
	);

	// direction and resolution are sampled with the detected edge
	assign req.dir_fwd = dir_in;
	assign req.res = resolution_select;

	// ****************************************
	// grid of valid angles for the sampled resolution
	// ****************************************
	// unused code 7 falls back to sixteenth so a bad strap never stalls motion
	always_comb begin
		offset = mat_pkg::ZERO_OFFSET;
		case (req.res)
			mat_pkg::RES_FULL1: grid = mat_pkg::GRID_FULL;
			mat_pkg::RES_FULL2: begin
				grid = mat_pkg::GRID_FULL;
				offset = mat_pkg::FULL2_OFFSET;
			end
			mat_pkg::RES_HALF_COMP: grid = mat_pkg::GRID_HALF;
			mat_pkg::RES_HALF_UNCOMP: grid = mat_pkg::GRID_HALF;
			mat_pkg::RES_QUARTER: grid = mat_pkg::GRID_QUARTER;
			mat_pkg::RES_EIGHTH: grid = mat_pkg::GRID_EIGHTH;
			default: grid = mat_pkg::GRID_SIXTEENTH;
		endcase
	end

	// ****************************************
	// next angle on the new grid
	// ****************************************
	// work relative to the grid offset so off-grid angles snap to the
	// nearest valid one in the direction of travel; 6-bit math wraps at 64
	always_comb begin
		rel = angle_reg - offset;
		rel_floor = rel & ~(grid - 6'h01);
		if (req.dir_fwd) begin
			rel_new = rel_floor + grid;
		end else if (rel_floor == rel) begin
			rel_new = rel - grid;
		end else begin
			rel_new = rel_floor;
		end
		angle_next = rel_new + offset;
	end

	// home depends on the selection present when homing happens
	assign home_sel = (resolution_select == mat_pkg::RES_FULL1) ?
		mat_pkg::HOME_ANGLE_FULL1 : mat_pkg::HOME_ANGLE;

	// ****************************************
	// control state
	// ****************************************
	// sleep holds the block homing; leaving it reloads home on the next clock
	always_comb begin
		case (state_reg)
			mat_pkg::ST_HOME: state_next = sleep_in ? mat_pkg::ST_HOME : mat_pkg::ST_RUN;
			mat_pkg::ST_RUN: state_next = sleep_in ? mat_pkg::ST_HOME : mat_pkg::ST_RUN;
			default: state_next = mat_pkg::ST_HOME;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= mat_pkg::ST_HOME;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// step angle counter
	// ****************************************
	// reset loads a constant; the selection-dependent home lands in ST_HOME
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			angle_reg <= mat_pkg::HOME_ANGLE;
		end else if (state_reg == mat_pkg::ST_HOME) begin
			angle_reg <= home_sel;
		end else if (step_rise) begin
			angle_reg <= angle_next;
		end
	end

	// one-cycle pulse after each accepted step
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= step_rise && (state_reg == mat_pkg::ST_RUN);
		end
	end

	// ****************************************
	// phase magnitude targets
	// ****************************************
	// uncompensated half step forces any nonzero phase to full scale, so the
	// in-between positions drive both phases at full current, signs from table
	assign uncomp = (resolution_select == mat_pkg::RES_HALF_UNCOMP);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			drive_reg <= '0;
		end else begin
			drive_reg.angle <= angle_reg;
			drive_reg.compensated <= ~uncomp;
			if (uncomp && (table_mag_a != mat_pkg::MAG_RESET)) begin
				drive_reg.mag_a <= full_scale_phase_entry;
			end else begin
				drive_reg.mag_a <= table_mag_a;
			end
			if (uncomp && (table_mag_b != mat_pkg::MAG_RESET)) begin
				drive_reg.mag_b <= full_scale_phase_entry;
			end else begin
				drive_reg.mag_b <= table_mag_b;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign angle_out = angle_reg;
	assign drive_out = drive_reg;
	assign step_done = done_reg;

	// ****************************************
	// assertions
	// ****************************************
	sequence s_run_edge;
		(state_reg == mat_pkg::ST_RUN) && step_rise && !sleep_in;
	endsequence

	sequence s_six_fwd;
		s_run_edge ##0 ((resolution_select == mat_pkg::RES_SIXTEENTH) && dir_in);
	endsequence

	sequence s_six_rev;
		s_run_edge ##0 ((resolution_select == mat_pkg::RES_SIXTEENTH) && !dir_in);
	endsequence

	chk_six_forward: assert property (@(posedge mclk) disable iff (!rstn)
		s_six_fwd |=> angle_reg == 6'($past(angle_reg) + 6'h01))
		else $error("sixteenth forward did not add one");

	chk_six_reverse: assert property (@(posedge mclk) disable iff (!rstn)
		s_six_rev |=> angle_reg == 6'($past(angle_reg) - 6'h01))
		else $error("sixteenth reverse did not subtract one");

	chk_wrap_top: assert property (@(posedge mclk) disable iff (!rstn)
		s_six_fwd ##0 (angle_reg == mat_pkg::ANGLE_MAX) |=> angle_reg == 6'h00)
		else $error("angle did not wrap from 63 to 0");

	chk_full1_grid: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 (resolution_select == mat_pkg::RES_FULL1)
		|=> angle_reg[3:0] == 4'h0)
		else $error("single-phase full step off grid");

	chk_full2_grid: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 (resolution_select == mat_pkg::RES_FULL2)
		|=> angle_reg[3:0] == 4'h8)
		else $error("two-phase full step off grid");

	chk_half_grid: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 ((resolution_select == mat_pkg::RES_HALF_COMP) ||
		(resolution_select == mat_pkg::RES_HALF_UNCOMP)) |=> angle_reg[2:0] == 3'h0)
		else $error("half step off grid");

	chk_quarter_grid: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 (resolution_select == mat_pkg::RES_QUARTER)
		|=> angle_reg[1:0] == 2'h0)
		else $error("quarter step off grid");

	chk_eighth_grid: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 (resolution_select == mat_pkg::RES_EIGHTH)
		|=> angle_reg[0] == 1'b0)
		else $error("eighth step off grid");

	chk_snap_forward: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge ##0 dir_in && (resolution_select == mat_pkg::RES_QUARTER)
		|=> (6'(angle_reg - $past(angle_reg)) >= 6'h01) &&
		(6'(angle_reg - $past(angle_reg)) <= 6'h04))
		else $error("forward snap overshot the quarter grid");

	chk_idle_hold: assert property (@(posedge mclk) disable iff (!rstn)
		(state_reg == mat_pkg::ST_RUN) && !step_rise && !sleep_in
		|=> $stable(angle_reg))
		else $error("angle moved without a step edge");

	chk_sleep_home: assert property (@(posedge mclk) disable iff (!rstn)
		sleep_in ##1 !sleep_in |=> angle_reg == $past(home_sel))
		else $error("angle not home after sleep");

	chk_uncomp_full: assert property (@(posedge mclk) disable iff (!rstn)
		uncomp && (table_mag_a != 6'h00) |=> drive_reg.mag_a == $past(full_scale_phase_entry))
		else $error("uncompensated phase not at full scale");

	chk_edge_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		step_rise |=> !step_rise)
		else $error("step edge longer than one cycle");

	chk_done_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		s_run_edge |=> step_done)
		else $error("accepted step gave no done pulse");

endmodule : mat_translator

//--- mat_ctrl_model.sv
// controller model that drives the step pin with legal pulse widths
`timescale 1ns/1ns
module mat_ctrl_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// request from the bench
	input wire logic go,
	input wire logic slow,
	// step pin and activity
	output logic step_in,
	output logic busy
);
	// ****************************************
	// pulse shaper
	// ****************************************
	logic [3:0] cnt_reg;
	// a request while busy is dropped, so the bench waits for idle first
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 4'h0;
		end else if (go && cnt_reg == 4'h0) begin
			cnt_reg <= slow ? 4'ha : 4'h4;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	// high for at least two cycles, then low for at least two
	assign step_in = slow ? (cnt_reg > 4'h5) : (cnt_reg > 4'h2);
	assign busy = (cnt_reg != 4'h0);
endmodule : mat_ctrl_model

//--- tb_top.sv
// self-checking bench for the microstep angle translator
`timescale 1ns/1ns
module tb_top;
	// ****************************************
	// signals
	// ****************************************
	logic mclk, rstn, step_in, dir_in, sleep_in, go, slow, busy, step_done;
	logic [2:0] resolution_select;
	logic [5:0] table_mag_a, table_mag_b, full_scale_phase_entry, angle_out;
	mat_pkg::mat_drive_type drive_out;
	int error_cnt = 0;
	int total_checks = 0;
	int i;
	// rows: resolution, direction, expected angle, starting from home 8
	logic [9:0] rows [21] = '{
		{3'h4, 1'h1, 6'h09}, {3'h4, 1'h0, 6'h08}, {3'h2, 1'h0, 6'h04}, {3'h2, 1'h0, 6'h00},
		{3'h2, 1'h0, 6'h3c}, {3'h4, 1'h0, 6'h3b}, {3'h4, 1'h0, 6'h3a}, {3'h4, 1'h0, 6'h39},
		{3'h2, 1'h1, 6'h3c}, {3'h1, 1'h1, 6'h00}, {3'h0, 1'h1, 6'h10}, {3'h5, 1'h1, 6'h18},
		{3'h5, 1'h0, 6'h08}, {3'h3, 1'h1, 6'h0a}, {3'h3, 1'h0, 6'h08}, {3'h6, 1'h1, 6'h10},
		{3'h7, 1'h1, 6'h11}, {3'h0, 1'h0, 6'h10}, {3'h5, 1'h1, 6'h18}, {3'h2, 1'h1, 6'h1c},
		{3'h1, 1'h0, 6'h18}};

	// ****************************************
	// clock, table stand-in and instances
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// table follows the angle; low nibble zero gives a zero phase b entry
	assign table_mag_a = angle_out ^ 6'h2a;
	assign table_mag_b = angle_out & 6'h0f;
	mat_ctrl_model u_ctrl (.mclk(mclk), .rstn(rstn), .go(go), .slow(slow),
		.step_in(step_in), .busy(busy));
	mat_translator dut (.mclk(mclk), .rstn(rstn), .step_in(step_in), .dir_in(dir_in),
		.resolution_select(resolution_select), .sleep_in(sleep_in),
		.table_mag_a(table_mag_a), .table_mag_b(table_mag_b),
		.full_scale_phase_entry(full_scale_phase_entry), .angle_out(angle_out),
		.drive_out(drive_out), .step_done(step_done));

	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 20) begin
			error_cnt++;
			close_out();
		end
	endtask : tmo
	// expected drive word; uncompensated half step forces full scale
	function automatic logic [18:0] exp_drive(input logic [5:0] a, input logic [2:0] r);
		logic [5:0] ma;
		logic [5:0] mb;
		ma = a ^ 6'h2a;
		mb = a & 6'h0f;
		if (r == mat_pkg::RES_HALF_UNCOMP) begin
			// full scale kept off 63 so a hardwired value would show
			return {a, (ma != 6'h00) ? 6'h3d : 6'h00, (mb != 6'h00) ? 6'h3d : 6'h00, 1'b0};
		end
		return {a, ma, mb, 1'b1};
	endfunction : exp_drive
	// one step edge, then angle and drive word against expectation
	task automatic step_once(input logic [2:0] r, input logic d, input logic s,
		input logic [5:0] e);
		int n;
		for (n = 0; n < 20 && busy === 1'b1; n++) @(posedge mclk);
		tmo(n);
		@(posedge mclk);
		resolution_select <= r;
		dir_in <= d;
		slow <= s;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		for (n = 0; n < 20 && step_done !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		tmo(n);
		chk({13'h0, angle_out}, {13'h0, e});
		@(posedge mclk);
		#1;
		chk(drive_out, exp_drive(e, r));
		chk({18'h0, step_done}, 19'h0);
	endtask : step_once
	// reset with a given resolution, home checked after release
	task automatic do_reset(input logic [2:0] r, input logic [5:0] home);
		@(posedge mclk);
		resolution_select <= r;
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk({drive_out[18:1], step_done}, 19'h0);
		chk({13'h0, angle_out}, 19'h8);
		@(posedge mclk);
		rstn <= 1'b1;
		repeat (5) @(posedge mclk);
		#1;
		chk({13'h0, angle_out}, {13'h0, home});
	endtask : do_reset

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		dir_in = 1'b0;
		sleep_in = 1'b0;
		go = 1'b0;
		slow = 1'b0;
		resolution_select = 3'h4;
		full_scale_phase_entry = 6'h3d;
		do_reset(3'h4, 6'h08);
		// resolution changes between edges without reset
		for (i = 0; i < 21; i++) begin
			step_once(rows[i][9:7], rows[i][6], i[0], rows[i][5:0]);
		end
		// sleep sends single-phase home and refuses steps
		@(posedge mclk);
		resolution_select <= 3'h0;
		sleep_in <= 1'b1;
		repeat (3) @(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (10) @(posedge mclk);
		#1;
		chk({13'h0, angle_out}, 19'h0);
		@(posedge mclk);
		sleep_in <= 1'b0;
		repeat (5) @(posedge mclk);
		step_once(3'h0, 1'b1, 1'b0, 6'h10);
		// two more resets in mid-run, compensated half step afterwards
		do_reset(3'h0, 6'h00);
		do_reset(3'h1, 6'h08);
		step_once(3'h1, 1'b1, 1'b1, 6'h10);
		// walk down to zero, then wrap both ways in sixteenth
		step_once(3'h1, 1'b0, 1'b0, 6'h08);
		step_once(3'h1, 1'b0, 1'b1, 6'h00);
		step_once(3'h4, 1'b0, 1'b0, 6'h3f);
		step_once(3'h4, 1'b1, 1'b1, 6'h00);
		close_out();
	end
endmodule : tb_top
